// ### inc/pd_caps_pkg.sv
// Purpose: Constants and carriers for the data message framer and caps advertiser
// Assumes: 10 MHz core clock, header fields already split out by the protocol engine
// Notes:   Power object sort key is bits 19:10 for every supply type
//
// Functional notes
// RULE1: A data message has a header plus one or more objects; nonzero count means data.
// RULE2: Type codes: 1 src caps, 2 request, 3 BIST, 4 sink caps, 5 battery, 6 alert, 15 vendor.
// RULE3: Every other type code is reserved and is never transmitted.
// RULE4: Each type may come only from its listed sender roles.
// RULE5: BIST and vendor types may use any packet start; others use the port start only.
// RULE6: Caps messages hold a 5 V fixed object plus at most six more objects.
// RULE7: The 5 V fixed object comes first, then other fixed objects by rising voltage.
// RULE8: Battery objects then variable objects follow, each by rising minimum voltage.
// RULE9: Each power object is exactly one 32-bit word.
// RULE10: Bits 31:30 give supply type: fixed, battery, variable; 11 is reserved.
// RULE11: The partner sink requests only an object index that was last offered.
// RULE12: Offered current is capped at the receptacle and plug limit.
// RULE13: After reset, power-on or attach, send source caps at every advertising timeout.
// RULE14: Keep repeating source caps up to the configured count until acknowledged.
// RULE15: Otherwise source caps go out only from ready on power change or on request.
// RULE16: A dual-role port answers both caps requests whatever its present power role.
// RULE17: The partner sink issues hard reset when no source caps arrive in time.
// RULE18: Voltage and current values in power objects are absolute.
// RULE19: The object kind is decided by the header type field alone.
// RULE20: Fixed object: bits 19:10 voltage in 50 mV, bits 9:0 current in 10 mA.
// RULE21: The header object count equals the number of objects appended, one to seven.
package pd_caps_pkg;

    // Data message types
    localparam logic [4:0] MT_SRC_CAP = 5'h01;
    localparam logic [4:0] MT_REQUEST = 5'h02;
    localparam logic [4:0] MT_BIST    = 5'h03;
    localparam logic [4:0] MT_SNK_CAP = 5'h04;
    localparam logic [4:0] MT_BATT    = 5'h05;
    localparam logic [4:0] MT_ALERT   = 5'h06;
    localparam logic [4:0] MT_VENDOR  = 5'h0F;

    // Sender roles and packet starts
    localparam logic [1:0] ROLE_SRC  = 2'h0;
    localparam logic [1:0] ROLE_SNK  = 2'h1;
    localparam logic [1:0] ROLE_DRP  = 2'h2;
    localparam logic [1:0] ROLE_PLUG = 2'h3;
    localparam logic [2:0] SOP_PORT  = 3'h0;

    // Power object fields
    localparam int         PDO_TYPE_HI = 31;
    localparam int         PDO_TYPE_LO = 30;
    localparam int         PDO_VOLT_HI = 19;
    localparam int         PDO_VOLT_LO = 10;
    localparam int         PDO_CURR_HI = 9;
    localparam logic [1:0] PDO_FIXED   = 2'h0;
    localparam logic [1:0] PDO_RSVD    = 2'h3;
    localparam logic [9:0] VSAFE5V     = 10'h064;
    localparam int         MAX_PDO     = 7;

    // Timing and counts
    localparam int CLK_MHZ        = 10;
    localparam int T_SRC_CAP_US   = 150000;
    localparam int SRC_CAP_CYC    = T_SRC_CAP_US * CLK_MHZ;
    localparam int N_CAPS_COUNT   = 50;

    // Received header to check
    typedef struct packed {
        logic       valid;
        logic [2:0] sop;
        logic [2:0] ndo;
        logic [4:0] mtype;
        logic [1:0] role;
    } rx_hdr_s;

    // Check verdict
    typedef struct packed {
        logic       valid;
        logic       is_data;
        logic       known;
        logic       role_ok;
        logic       sop_ok;
        logic [4:0] mtype;
    } rx_chk_s;

    // Transmit word stream
    typedef struct packed {
        logic        valid;
        logic        first;
        logic        last;
        logic [4:0]  mtype;
        logic [2:0]  ndo;
        logic [31:0] word;
    } tx_word_s;

endpackage

// ### hw/pd_caps_adv.sv
// Purpose: Data message checker and capabilities message builder and advertiser
// Assumes: Inputs synchronous to i_core_clk; protocol engine reports acks and failures
// Notes:   Badly ordered tables are sent as the 5 V object alone
`timescale 1ns/100ps
module pd_caps_adv #(
    parameter int SRC_CAP_CYC  = pd_caps_pkg::SRC_CAP_CYC,
    parameter int N_CAPS_COUNT = pd_caps_pkg::N_CAPS_COUNT
) (
    // Clock, reset, enable
    input  wire logic                   i_core_clk,
    input  wire logic                   i_arst_n,
    input  wire logic                   i_clk_en,
    // Policy inputs
    input  wire logic [1:0]             i_role,
    input  wire logic                   i_adv_start,
    input  wire logic                   i_pwr_change,
    input  wire logic                   i_get_src_cap,
    input  wire logic                   i_get_snk_cap,
    input  wire logic [9:0]             i_max_curr,
    input  wire logic [31:0]            i_src_pdo [7],
    input  wire logic [2:0]             i_src_cnt,
    input  wire logic [31:0]            i_snk_pdo [7],
    input  wire logic [2:0]             i_snk_cnt,
    // Receive check
    input  wire pd_caps_pkg::rx_hdr_s   i_rx_hdr,
    output pd_caps_pkg::rx_chk_s        o_rx_chk,
    // Transmit stream
    input  wire logic                   i_tx_ready,
    input  wire logic                   i_tx_goodcrc,
    input  wire logic                   i_tx_fail,
    output pd_caps_pkg::tx_word_s       o_tx,
    output logic                        o_src_ready,
    output logic                        o_adv_gave_up
);

    typedef enum logic [2:0] {S_IDLE, S_ADV_WAIT, S_SEND, S_WAIT_ACK, S_READY} state_e;

    state_e      state_q;
    logic        adv_q;
    logic        snk_sel_q;
    logic [2:0]  idx_q;
    logic [2:0]  cnt_q;
    logic [31:0] tmr_q;
    logic [7:0]  caps_cnt_q;
    logic [31:0] pdo_w;
    logic        src_ok;
    logic        snk_ok;

    // Known data type test
    function automatic logic known_type(input logic [4:0] t);
        known_type = (t >= pd_caps_pkg::MT_SRC_CAP && t <= pd_caps_pkg::MT_ALERT)
                     || t == pd_caps_pkg::MT_VENDOR;
    endfunction

    // Sender role allowed for type
    function automatic logic role_allowed(input logic [4:0] t, input logic [1:0] r);
        case (t)
            pd_caps_pkg::MT_REQUEST: role_allowed = (r == pd_caps_pkg::ROLE_SNK);
            pd_caps_pkg::MT_ALERT:   role_allowed = (r == pd_caps_pkg::ROLE_SRC);
            pd_caps_pkg::MT_VENDOR, pd_caps_pkg::MT_BIST:
                role_allowed = (r != pd_caps_pkg::ROLE_DRP) || (t == pd_caps_pkg::MT_BIST);
            pd_caps_pkg::MT_SRC_CAP, pd_caps_pkg::MT_SNK_CAP, pd_caps_pkg::MT_BATT:
                role_allowed = (r != pd_caps_pkg::ROLE_PLUG);
            default:                 role_allowed = 1'b0;
        endcase
    endfunction

    // Table order and type check
    function automatic logic table_ok(input logic [31:0] p [7], input logic [2:0] n);
        logic [2:0] k;
        table_ok = (n != 3'h0)
            && p[0][pd_caps_pkg::PDO_TYPE_HI:pd_caps_pkg::PDO_TYPE_LO] == pd_caps_pkg::PDO_FIXED
            && p[0][pd_caps_pkg::PDO_VOLT_HI:pd_caps_pkg::PDO_VOLT_LO] == pd_caps_pkg::VSAFE5V;
        for (int i = 1; i < pd_caps_pkg::MAX_PDO; i++) begin
            k = 3'(i);
            if (k < n) begin
                if (p[i][31:30] == pd_caps_pkg::PDO_RSVD || p[i][31:30] < p[i-1][31:30])
                    table_ok = 1'b0;
                else if (p[i][31:30] == p[i-1][31:30] && p[i][19:10] <= p[i-1][19:10])
                    table_ok = 1'b0;
            end
        end
    endfunction

    assign src_ok = table_ok(i_src_pdo, i_src_cnt); // RULE6 RULE7 RULE8 RULE10
    assign snk_ok = table_ok(i_snk_pdo, i_snk_cnt); // RULE6 RULE7 RULE8 RULE10

    // Current word with fixed and variable current capped in source caps only
    always_comb begin
        pdo_w = snk_sel_q ? i_snk_pdo[idx_q] : i_src_pdo[idx_q]; // RULE9 RULE19
        // A cut table still leads with the 5 V fixed object
        if (!(snk_sel_q ? snk_ok : src_ok)) begin
            pdo_w[pd_caps_pkg::PDO_TYPE_HI:pd_caps_pkg::PDO_TYPE_LO] =
                pd_caps_pkg::PDO_FIXED; // RULE6 RULE7
            pdo_w[pd_caps_pkg::PDO_VOLT_HI:pd_caps_pkg::PDO_VOLT_LO] =
                pd_caps_pkg::VSAFE5V; // RULE6 RULE7
        end
        if (!snk_sel_q && pdo_w[31:30] != 2'h1 && pdo_w[9:0] > i_max_curr) begin
            pdo_w[pd_caps_pkg::PDO_CURR_HI:0] = i_max_curr; // RULE12 RULE18 RULE20
        end
    end

    // Receive header check
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rx_chk <= '0;
        end else if (i_clk_en) begin
            o_rx_chk.valid   <= i_rx_hdr.valid;
            o_rx_chk.is_data <= i_rx_hdr.ndo != 3'h0; // RULE1
            o_rx_chk.known   <= known_type(i_rx_hdr.mtype); // RULE2 RULE3
            o_rx_chk.role_ok <= role_allowed(i_rx_hdr.mtype, i_rx_hdr.role); // RULE4
            o_rx_chk.sop_ok  <= i_rx_hdr.mtype == pd_caps_pkg::MT_BIST
                                || i_rx_hdr.mtype == pd_caps_pkg::MT_VENDOR
                                || i_rx_hdr.sop == pd_caps_pkg::SOP_PORT; // RULE5
            o_rx_chk.mtype   <= i_rx_hdr.mtype;
        end
    end

    // Advertising and reply sequencer
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q    <= S_IDLE;
            adv_q      <= 1'b0;
            snk_sel_q  <= 1'b0;
            cnt_q      <= 3'h0;
            tmr_q      <= '0;
            caps_cnt_q <= '0;
            o_adv_gave_up <= 1'b0;
        end else if (i_clk_en) begin
            if (i_adv_start && i_role != pd_caps_pkg::ROLE_SNK) begin
                state_q    <= S_ADV_WAIT; // RULE13
                adv_q      <= 1'b1;
                snk_sel_q  <= 1'b0;
                tmr_q      <= '0;
                caps_cnt_q <= '0;
                o_adv_gave_up <= 1'b0;
            end else begin
                case (state_q)
                    S_ADV_WAIT: begin
                        tmr_q <= tmr_q + 32'h0000_0001;
                        if (tmr_q >= 32'(SRC_CAP_CYC - 1)) begin
                            state_q <= S_SEND; // RULE13
                            cnt_q   <= src_ok ? i_src_cnt : 3'h1; // RULE21
                        end
                    end
                    S_SEND: begin
                        if (i_tx_ready && o_tx.valid && o_tx.last) state_q <= S_WAIT_ACK;
                    end
                    S_WAIT_ACK: begin
                        if (i_tx_goodcrc) begin
                            state_q <= S_READY; // RULE14
                            adv_q   <= 1'b0;
                        end else if (i_tx_fail && adv_q) begin
                            tmr_q      <= '0;
                            caps_cnt_q <= caps_cnt_q + 8'h01;
                            if (32'(caps_cnt_q) + 1 >= N_CAPS_COUNT) begin
                                state_q       <= S_IDLE; // RULE14
                                o_adv_gave_up <= 1'b1;
                            end else begin
                                state_q <= S_ADV_WAIT; // RULE14
                            end
                        end else if (i_tx_fail) begin
                            state_q <= S_READY;
                        end
                    end
                    S_READY: begin
                        if (i_get_snk_cap && i_role != pd_caps_pkg::ROLE_SRC) begin
                            state_q   <= S_SEND; // RULE16
                            snk_sel_q <= 1'b1;
                            cnt_q     <= snk_ok ? i_snk_cnt : 3'h1; // RULE21
                        end else if ((i_get_src_cap && i_role != pd_caps_pkg::ROLE_SNK)
                                     || (i_pwr_change && i_role != pd_caps_pkg::ROLE_SNK)) begin
                            state_q   <= S_SEND; // RULE15 RULE16
                            snk_sel_q <= 1'b0;
                            cnt_q     <= src_ok ? i_src_cnt : 3'h1; // RULE21
                        end
                    end
                    S_IDLE: begin
                        if (i_role == pd_caps_pkg::ROLE_SNK) state_q <= S_READY;
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    // Object index and transmit word
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            idx_q <= 3'h0;
            o_tx  <= '0;
        end else if (i_clk_en) begin
            if (state_q != S_SEND) begin
                idx_q <= 3'h0;
                o_tx  <= '0;
            end else if (!o_tx.valid || i_tx_ready) begin
                if (o_tx.valid && o_tx.last) begin
                    o_tx <= '0;
                end else begin
                    o_tx.valid <= 1'b1;
                    o_tx.first <= idx_q == 3'h0;
                    o_tx.last  <= idx_q == cnt_q - 3'h1;
                    o_tx.mtype <= snk_sel_q ? pd_caps_pkg::MT_SNK_CAP : pd_caps_pkg::MT_SRC_CAP;
                    o_tx.ndo   <= cnt_q; // RULE21 RULE1
                    o_tx.word  <= pdo_w; // RULE9
                    idx_q      <= idx_q + 3'h1;
                end
            end
        end
    end

    // Ready indication
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) o_src_ready <= 1'b0;
        else if (i_clk_en) o_src_ready <= state_q == S_READY;
    end

    // Checks
    a_ndo_nonzero: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE21
        o_tx.valid |-> o_tx.ndo != 3'h0) else $error("zero object count sent");
    a_type_caps: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE3
        o_tx.valid |-> known_type(o_tx.mtype)) else $error("reserved type sent");
    a_first_safe: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE7
        o_tx.valid && o_tx.first |-> o_tx.word[31:30] == 2'h0 && (o_tx.word[19:10] ==
        pd_caps_pkg::VSAFE5V)) else $error("first object not 5 V fixed");
    a_no_rsvd_pdo: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE10
        o_tx.valid |-> o_tx.word[31:30] != pd_caps_pkg::PDO_RSVD) else $error("reserved pdo");
    a_curr_cap: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE12
        o_tx.valid && o_tx.mtype == pd_caps_pkg::MT_SRC_CAP && o_tx.word[31:30] != 2'h1
        |-> o_tx.word[9:0] <= i_max_curr) else $error("current above limit");
    a_hold_stall: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE9
        i_clk_en && o_tx.valid && !i_tx_ready ##1 i_clk_en |-> $stable(o_tx))
        else $error("word changed while stalled");
    a_sop_check: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE5
        i_clk_en && i_rx_hdr.mtype == pd_caps_pkg::MT_REQUEST && i_rx_hdr.sop != 3'h0
        |=> !o_rx_chk.sop_ok) else $error("request off port start accepted");
    a_role_check: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE4
        i_clk_en && i_rx_hdr.mtype == pd_caps_pkg::MT_REQUEST && i_rx_hdr.role !=
        pd_caps_pkg::ROLE_SNK |=> !o_rx_chk.role_ok) else $error("bad request role passed");
    a_data_flag: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE1
        i_clk_en |=> o_rx_chk.is_data == ($past(i_rx_hdr.ndo) != 3'h0))
        else $error("data flag wrong");
    a_ready_quiet: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE15
        state_q == S_READY && i_clk_en && !i_adv_start && !i_get_src_cap && !i_get_snk_cap
        && !i_pwr_change |=> state_q == S_READY) else $error("unprompted caps from ready");
    a_sink_no_adv: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE13
        state_q != S_ADV_WAIT && i_role == pd_caps_pkg::ROLE_SNK && i_adv_start && i_clk_en
        |=> state_q != S_ADV_WAIT) else $error("sink advertised");
    a_give_up_cnt: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE14
        $rose(o_adv_gave_up) |-> 32'(caps_cnt_q) >= N_CAPS_COUNT)
        else $error("gave up too early");
    a_sop_vendor: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE5
        i_clk_en && i_rx_hdr.mtype == pd_caps_pkg::MT_VENDOR |=> o_rx_chk.sop_ok)
        else $error("vendor start refused");
    a_rsvd_type: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE3
        i_clk_en && i_rx_hdr.mtype == 5'h00 |=> !o_rx_chk.known && !o_rx_chk.role_ok)
        else $error("reserved type passed");

    c_adv_ack: cover property (@(posedge i_core_clk) state_q == S_WAIT_ACK && adv_q
        && i_tx_goodcrc);
    c_retry: cover property (@(posedge i_core_clk) state_q == S_WAIT_ACK && adv_q
        && i_tx_fail);
    c_snk_caps: cover property (@(posedge i_core_clk) o_tx.valid && o_tx.last
        && o_tx.mtype == pd_caps_pkg::MT_SNK_CAP);
    c_cut_table: cover property (@(posedge i_core_clk) state_q == S_SEND && !snk_sel_q
        && !src_ok);
    c_gave_up: cover property (@(posedge i_core_clk) $rose(o_adv_gave_up));

endmodule

// ### verification/pd_caps_partner.sv
// Purpose: Far-end model that takes the transmit stream and acknowledges messages
// Assumes: A word is taken at a rising edge where valid and ready are both high
// Notes:   Slow mode stalls ready at random; fail mode reports a failed send
`timescale 1ns/100ps
module pd_caps_partner (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_arst_n,
    // Stream from the block and test modes
    input  wire logic i_valid,
    input  wire logic i_last,
    input  wire logic i_slow,
    input  wire logic i_fail_mode,
    // Answers
    output logic      o_ready = 1'b1,
    output logic      o_goodcrc = 1'b0,
    output logic      o_fail = 1'b0
);
    int          seed = 32'h78d5_18af;
    logic        took = 1'b0;
    logic        pend = 1'b0;
    int          gap  = 0;
    // Note the edge where the last word of a message is taken
    // Only answers what it was offered; never asks for anything else
    always @(posedge i_core_clk) begin
        took <= i_valid === 1'b1 && o_ready && i_last === 1'b1;
    end
    // Stall when slow, then answer once, seen five rising edges after the last word is taken
    always @(negedge i_core_clk) begin
        o_ready   <= i_slow ? 1'($random(seed)) : 1'b1;
        o_goodcrc <= i_arst_n && pend && gap == 0 && !i_fail_mode;
        o_fail    <= i_arst_n && pend && gap == 0 && i_fail_mode;
        pend      <= i_arst_n && (took || (pend && gap != 0));
        gap       <= took ? 3 : gap - 1;
    end
endmodule

// ### verification/testbench.sv
// Purpose: Self-checking bench for the data message checker and caps advertiser
// Assumes: Short advertising timer and repeat count set at the instance
// Notes:   Expected words and verdicts queue up and a monitor compares them
`timescale 1ns/100ps
module testbench;
    localparam int CAP_CYC = 20;
    localparam int N_CAPS  = 3;
    logic                  i_core_clk = 1'b0;
    logic                  i_arst_n   = 1'b0;
    logic [1:0]            role       = pd_caps_pkg::ROLE_SRC;
    logic                  adv        = 1'b0;
    logic [2:0]            req        = 3'h0;
    logic [9:0]            max_curr   = 10'h12c;
    logic [31:0]           src_t [7];
    logic [31:0]           snk_t [7];
    logic [31:0]           good  [7];
    logic [2:0]            src_cnt    = 3'h4;
    logic [2:0]            snk_cnt    = 3'h3;
    pd_caps_pkg::rx_hdr_s  hdr        = '0;
    pd_caps_pkg::rx_chk_s  chk;
    pd_caps_pkg::tx_word_s tx, held;
    pd_caps_pkg::tx_word_s txq [$];
    pd_caps_pkg::rx_chk_s  rxq [$];
    logic                  rdy, gcrc, fl, src_ready, gave_up;
    logic                  slow = 1'b0, fail_mode = 1'b0, hold_chk = 1'b0, clk_en = 1'b1;
    int                    seed = 32'h78d5_18af;
    int                    bad_count = 0, n_compared = 0, cycles = 0;

    pd_caps_adv #(.SRC_CAP_CYC(CAP_CYC), .N_CAPS_COUNT(N_CAPS)) u_pd_caps_adv (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_clk_en(clk_en), .i_role(role),
        .i_adv_start(adv), .i_pwr_change(req[0]), .i_get_src_cap(req[1]),
        .i_get_snk_cap(req[2]), .i_max_curr(max_curr), .i_src_pdo(src_t),
        .i_src_cnt(src_cnt), .i_snk_pdo(snk_t), .i_snk_cnt(snk_cnt), .i_rx_hdr(hdr),
        .o_rx_chk(chk), .i_tx_ready(rdy), .i_tx_goodcrc(gcrc), .i_tx_fail(fl), .o_tx(tx),
        .o_src_ready(src_ready), .o_adv_gave_up(gave_up));
    pd_caps_partner u_pd_caps_partner (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_valid(tx.valid), .i_last(tx.last),
        .i_slow(slow), .i_fail_mode(fail_mode), .o_ready(rdy), .o_goodcrc(gcrc), .o_fail(fl));

    // Clock and hang guard
    always #50 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (exp !== got) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [31:0] mk(input logic [1:0] ty, input logic [9:0] vo);
        mk = {ty, 10'h000, vo, 10'($random(seed))};
    endfunction

    // Verdict expected for one received header
    function automatic pd_caps_pkg::rx_chk_s rx_exp(input pd_caps_pkg::rx_hdr_s h);
        pd_caps_pkg::rx_chk_s e;
        e.valid   = 1'b1;
        e.is_data = h.ndo != 3'h0;
        e.mtype   = h.mtype;
        e.known   = h.mtype inside {[5'h01:5'h06], pd_caps_pkg::MT_VENDOR};
        e.sop_ok  = h.mtype inside {pd_caps_pkg::MT_BIST, pd_caps_pkg::MT_VENDOR}
                    || h.sop == pd_caps_pkg::SOP_PORT;
        case (h.mtype)
            pd_caps_pkg::MT_REQUEST: e.role_ok = h.role == pd_caps_pkg::ROLE_SNK;
            pd_caps_pkg::MT_ALERT:   e.role_ok = h.role == pd_caps_pkg::ROLE_SRC;
            pd_caps_pkg::MT_VENDOR:  e.role_ok = h.role != pd_caps_pkg::ROLE_DRP;
            pd_caps_pkg::MT_BIST:    e.role_ok = 1'b1;
            default:                 e.role_ok = e.known && h.role != pd_caps_pkg::ROLE_PLUG;
        endcase
        return e;
    endfunction

    // Queue the words of a caps message, cut to one word if the table is badly formed
    task automatic push_msg(input logic [4:0] mt, input logic [31:0] t [7],
                            input logic [2:0] cnt, input logic clamp, input int reps);
        logic                  ok;
        logic [2:0]            n;
        logic [31:0]           v;
        pd_caps_pkg::tx_word_s w;
        ok = cnt != 3'h0 && t[0][31:30] == pd_caps_pkg::PDO_FIXED
             && t[0][19:10] == pd_caps_pkg::VSAFE5V;
        for (int k = 1; k < cnt; k++) begin
            if (t[k][31:30] == pd_caps_pkg::PDO_RSVD || t[k][31:30] < t[k-1][31:30])
                ok = 1'b0;
            if (t[k][31:30] == t[k-1][31:30] && t[k][19:10] <= t[k-1][19:10])
                ok = 1'b0;
        end
        n = ok ? cnt : 3'h1;
        repeat (reps) for (int k = 0; k < n; k++) begin
            v = t[k];
            if (!ok) begin
                v[31:30] = pd_caps_pkg::PDO_FIXED;
                v[19:10] = pd_caps_pkg::VSAFE5V;
            end
            if (clamp && v[31:30] != 2'b01 && v[9:0] > max_curr)
                v[9:0] = max_curr;
            w = '{1'b1, k == 0, k == n - 1, mt, n, v};
            txq.push_back(w);
        end
    endtask

    task automatic wait_ready(input int lim);
        for (int k = 0; k < lim && !(txq.size() == 0 && src_ready === 1'b1); k++)
            @(negedge i_core_clk);
    endtask

    // Pulse one request in the ready state and expect an answer or silence
    task automatic ask(input int which, input logic answer);
        if (answer && which == 2)
            push_msg(pd_caps_pkg::MT_SNK_CAP, snk_t, snk_cnt, 1'b0, 1);
        else if (answer)
            push_msg(pd_caps_pkg::MT_SRC_CAP, src_t, src_cnt, 1'b1, 1);
        @(negedge i_core_clk);
        req[which] = 1'b1;
        @(negedge i_core_clk);
        req = 3'h0;
        if (answer)
            wait_ready(400);
        else
            repeat (12) @(negedge i_core_clk);
        check("ready state", 1, src_ready);
    endtask

    // Compare taken words and verdicts with the oldest notes, held words with the last cycle
    always @(posedge i_core_clk) begin
        pd_caps_pkg::rx_chk_s e;
        if (hold_chk)
            check("held word", held, tx);
        hold_chk <= tx.valid === 1'b1 && rdy === 1'b0;
        held     <= tx;
        if (tx.valid === 1'b1 && rdy === 1'b1) begin
            if (txq.size() == 0)
                check("unexpected word", 0, tx);
            else
                check("tx word", txq.pop_front(), tx);
        end
        if (chk.valid === 1'b1 && rxq.size() != 0) begin
            e = rxq.pop_front();
            check("rx verdict", e & (e.known ? 10'h3ff : 10'h3df),
                  chk & (e.known ? 10'h3ff : 10'h3df));
        end
    end

    initial begin
        int k;
        src_t = '{mk(2'b00, 10'h064), mk(2'b00, 10'h0b4), mk(2'b01, 10'h064),
                  mk(2'b10, 10'h078), 32'h0, 32'h0, 32'h0};
        snk_t = '{mk(2'b00, 10'h064), mk(2'b00, 10'h0f0), mk(2'b10, 10'h064),
                  32'h0, 32'h0, 32'h0, 32'h0};
        repeat (6) @(negedge i_core_clk);
        i_arst_n = 1'b1;
        for (k = 0; k < 128; k++) begin
            hdr = '{1'b1, 3'($random(seed)), 3'($random(seed)), 5'(k), 2'($random(seed))};
            rxq.push_back(rx_exp(hdr));
            @(negedge i_core_clk);
        end
        hdr = '0;
        repeat (3) @(negedge i_core_clk);
        $display("test receive check done");
        fail_mode = 1'b1;
        push_msg(pd_caps_pkg::MT_SRC_CAP, src_t, src_cnt, 1'b1, N_CAPS);
        adv = 1'b1;
        @(negedge i_core_clk);
        adv = 1'b0;
        for (k = 0; k < 100 && tx.valid !== 1'b1; k++) @(negedge i_core_clk);
        check("advert delay", 1, k >= CAP_CYC && k <= CAP_CYC + 4);
        for (k = 0; k < 3000 && gave_up !== 1'b1; k++) @(negedge i_core_clk);
        check("gave up", 1, gave_up);
        check("repeats left", 0, txq.size());
        fail_mode = 1'b0;
        slow = 1'b1;
        push_msg(pd_caps_pkg::MT_SRC_CAP, src_t, src_cnt, 1'b1, 1);
        adv = 1'b1;
        @(negedge i_core_clk);
        adv = 1'b0;
        wait_ready(600);
        check("gave up cleared", 0, gave_up);
        $display("test advertising done");
        ask(0, 1'b1);
        ask(2, 1'b0);
        clk_en = 1'b0;
        ask(1, 1'b0);
        clk_en = 1'b1;
        good = src_t;
        for (k = 0; k < 3; k++) begin
            src_t = good;
            case (k)
                0: src_t[1][31:30] = 2'b11;
                1: src_t[0][19:10] = 10'h0b4;
                default: begin
                    src_t[2][31:30] = 2'b10;
                    src_t[3][31:30] = 2'b01;
                end
            endcase
            ask(1, 1'b1);
        end
        src_t = good;
        $display("test source requests done");
        role = pd_caps_pkg::ROLE_DRP;
        ask(2, 1'b1);
        ask(1, 1'b1);
        role = pd_caps_pkg::ROLE_SNK;
        adv = 1'b1;
        @(negedge i_core_clk);
        adv = 1'b0;
        repeat (CAP_CYC + 8) @(negedge i_core_clk);
        ask(1, 1'b0);
        $display("test role requests done");
        test_done();
    end
endmodule
